// ### ddr_pseudo_static_memory_bus_transactions_bench.sv
// self-checking bench: host and memory ends joined over the link
`timescale 1ns/10ps
module ddr_pseudo_static_memory_bus_transactions_bench;
    import psr_pkg::*;
    logic              clk, reset, reqValid, reqWrite, reqLinear;
    logic [ADDR_W-1:0] reqAddr;
    logic [7:0]        reqLen;
    logic              reqReady, wrTake, rdValid, refreshSeen, refreshDue;
    logic [WORD_W-1:0] wrData, rdData;
    logic [1:0]        wrMask;
    logic [WORD_W-1:0] wd [0:31];
    logic [1:0]        wm [0:31];
    logic [WORD_W-1:0] rd [0:31];
    logic [DQ_W-1:0]   cmd [0:5];
    int                nRd, cmdN, errors, n_checks;

    psr_link_if link ();
    psr_host psr_host_inst (.clk, .reset, .reqValid, .reqWrite, .reqLinear,
        .reqAddr, .reqLen, .reqReady, .wrData, .wrMask, .wrTake, .rdData,
        .rdValid, .refreshSeen, .link(link));
    psr_device psr_device_inst (.link(link), .refreshDue(refreshDue));
    psr_link_checker psr_link_checker_inst (.clk, .reset, .csN(link.csN),
        .ck(link.ck), .resetN(link.resetN), .hostDqOe(link.hostDqOe),
        .hostStrobeOe(link.hostStrobeOe), .devDqOe(link.devDqOe),
        .devStrobeOe(link.devStrobeOe), .devStrobe(link.devStrobe),
        .hostDq(link.hostDq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // bytes are taken mid-eye, on both link clock edges
    always @(negedge link.csN) cmdN = 0;
    always @(link.ck) begin
        if (link.csN === 1'b0 && cmdN < 6) begin
            cmd[cmdN] = link.dq;
            cmdN++;
        end
    end

    function automatic logic [WORD_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return a[15:0] ^ 16'hc3a5;
    endfunction : pat

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic fill(input logic [ADDR_W-1:0] a);
        for (int i = 0; i < 32; i++) begin
            wd[i] = pat(a + ADDR_W'(i));
            wm[i] = 2'b00;
        end
    endtask : fill

    task automatic xfer(input logic w, input logic lin,
                        input logic [ADDR_W-1:0] a, input int n);
        int k;
        int t;
        logic low;
        k = 0;
        nRd = 0;
        low = 1'b0;
        for (t = 0; t < 100 && reqReady !== 1'b1; t++) @(negedge clk);
        if (t == 100) begin
            errors++;
            stop_test();
        end
        @(negedge clk);
        reqValid = 1'b1;
        reqWrite = w;
        reqLinear = lin;
        reqAddr = a;
        reqLen = 8'(n);
        wrData = wd[0];
        wrMask = wm[0];
        for (t = 0; t < 3000; t++) begin
            @(posedge clk);
            #1;
            if (wrTake === 1'b1) k++;
            if (rdValid === 1'b1 && nRd < 32) begin
                rd[nRd] = rdData;
                nRd++;
            end
            if (reqReady === 1'b0) low = 1'b1;
            if (low && reqReady === 1'b1) break;
            @(negedge clk);
            reqValid = 1'b0;
            wrData = wd[k % 32];
            wrMask = wm[k % 32];
        end
        if (t == 3000) begin
            errors++;
            stop_test();
        end
        chk(32'(cmd[0][7]), 32'(!w));
        chk(32'(cmd[0][5]), 32'(lin));
        chk(32'({cmd[1][1:0], cmd[2], cmd[3]}),
            32'(a[ADDR_W-1:COL_W]));
        chk(32'(cmd[5][2:0]), 32'(a[2:0]));
        chk(32'(w ? k : nRd), 32'(n));
    endtask : xfer

    task automatic t_wrap;
        fill(21'h000100);
        xfer(1'b1, 1'b1, 21'h000100, 8);
        xfer(1'b0, 1'b0, 21'h000105, 8);
        for (int i = 0; i < 8; i++)
            chk(32'(rd[i]), 32'(pat({18'h00020, 3'(5 + i)})));
        $display("t_wrap done");
    endtask : t_wrap

    task automatic t_mask;
        logic [WORD_W-1:0] p0;
        logic [WORD_W-1:0] p1;
        p0 = pat(21'h000102);
        p1 = pat(21'h000103);
        wd[0] = 16'h0f0f;
        wm[0] = 2'b10;
        wd[1] = 16'h0f0f;
        wm[1] = 2'b01;
        xfer(1'b1, 1'b1, 21'h000102, 2);
        xfer(1'b0, 1'b1, 21'h000102, 2);
        chk(32'(rd[0]), 32'({p0[15:8], 8'h0f}));
        chk(32'(rd[1]), 32'({8'h0f, p1[7:0]}));
        $display("t_mask done");
    endtask : t_mask

    task automatic t_linear;
        fill(21'h000206);
        xfer(1'b1, 1'b1, 21'h000206, 10);
        xfer(1'b0, 1'b1, 21'h000206, 10);
        for (int i = 0; i < 10; i++)
            chk(32'(rd[i]), 32'(pat(21'h000206 + 21'(i))));
        $display("t_linear done");
    endtask : t_linear

    // long bursts exhaust the refresh budget, data must survive it
    task automatic t_refresh;
        logic seen;
        seen = 1'b0;
        fill(21'h001000);
        for (int j = 0; j < 6 && !seen; j++) begin
            xfer(1'b1, 1'b1, 21'h001000, 32);
            if (refreshSeen === 1'b1) seen = 1'b1;
        end
        chk(32'(seen), 32'h1);
        chk(32'(refreshDue), 32'h0);
        xfer(1'b0, 1'b1, 21'h001000, 32);
        for (int i = 0; i < 32; i++)
            chk(32'(rd[i]), 32'(pat(21'h001000 + 21'(i))));
        $display("t_refresh done");
    endtask : t_refresh

    initial begin
        reset = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqLinear = 1'b0;
        reqAddr = '0;
        reqLen = 8'h00;
        wrData = '0;
        wrMask = 2'b00;
        errors = 0;
        n_checks = 0;
        cmdN = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        t_wrap();
        t_mask();
        // a second reset in mid-run must release the lanes again
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_linear();
        t_refresh();
        stop_test();
    end
endmodule : ddr_pseudo_static_memory_bus_transactions_bench

// ### psr_device.sv
// memory end of the link: command decode, bursts, masking, refresh
`timescale 1ns/10ps

// How it works
// [RULE1] refresh runs inside, only outside data transfer
// [RULE2] host bounds bursts, honours refresh latency
// [RULE3] each cycle moves one word, two bytes
// [RULE4] shared lanes, captured on link clock edges
// [RULE5] select, six bytes, latency, data until deselect
// [RULE6] strobe high in command phase demands refresh
// [RULE7] read strobe toggles with edge-aligned bytes
// [RULE8] write strobe high masks, low writes byte
// [RULE9] host centres write bytes on clock edges
// [RULE10] burst advances one word per cycle
// [RULE11] wrapped burst wraps inside its aligned group
// [RULE12] linear burst increments until deselect
// [RULE13] burst type chosen per command
// [RULE14] word addressing, bytes placed by mask
// [RULE15] first two cycles row, third column
// [RULE16] linear burst prefetches next row
// [RULE17] select falls while link clock low
// [RULE18] bit seven on top lane, bit zero bottom
// [RULE19] reset low releases lanes and reinitialises
// [RULE20] three command words over three cycles
// [RULE21] deselected device releases lanes and strobe
// [RULE22] wrap base clears low group bits
module psr_device (
    psr_link_if.device link,
    output logic       refreshDue
);
    import psr_pkg::*;

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [DQ_W-1:0]   memHi [0:MEM_WORDS-1];
    logic [DQ_W-1:0]   memLo [0:MEM_WORDS-1];

    psr_dev_state_t    state;
    logic [1:0]        cmdCnt;
    logic [DQ_W-1:0]   cmdHi;
    logic [CMD_W-1:0]  cmdBits;
    logic              isRead;
    logic              isLinear;
    logic              extraLat;
    logic [7:0]        latCnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] curAddr;
    logic [ROW_W-1:0]  prefRow;
    logic [DQ_W-1:0]   rdHi;
    logic [DQ_W-1:0]   rdLoNext;
    logic [DQ_W-1:0]   rdLo;
    logic [DQ_W-1:0]   wrHi;
    logic              wrHiMask;
    logic              dataLive;
    logic [7:0]        burstCnt;

    // ------------------------------------------------------------
    // resets
    // ------------------------------------------------------------
    // the link clock stops between frames, so deselect must end the
    // frame on its own without waiting for a clock edge
    // [RULE19] reset pin clears
    wire devReset = ~link.resetN;
    // [RULE21] deselect ends frame
    wire txnClear = link.csN | devReset;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // [RULE15] row then column
    wire [ROW_W-1:0]  cmdRow = cmdBits[CMD_ROW_LSB +: ROW_W];
    wire [COL_W-1:0]  cmdCol = cmdBits[CMD_COL_LSB +: COL_W];
    wire [ADDR_W-1:0] cmdAddr = {cmdRow, cmdCol};
    // [RULE6] extra latency when refresh pending
    wire [7:0] latLoad = refreshDue ? 8'(REFRESH_LAT_CYCLES - 2)
                                    : 8'(INIT_LAT_CYCLES - 2);

    // ------------------------------------------------------------
    // burst address sequence
    // ------------------------------------------------------------
    wire              rowEnd = &addr[COL_W-1:0];
    // [RULE16] prefetched row on crossing
    wire [ADDR_W-1:0] linNext = rowEnd ? {prefRow, {COL_W{1'b0}}}
                                       : addr + 21'h000001;
    // [RULE22] group base masks low bits
    wire [ADDR_W-1:0] wrapBase = addr & ~WRAP_MASK;
    // [RULE11] wrap inside group
    wire [ADDR_W-1:0] wrapNext = wrapBase
                               | ((addr + 21'h000001) & WRAP_MASK);
    // [RULE13] per-command burst type
    wire [ADDR_W-1:0] nextAddr = isLinear ? linNext : wrapNext;

    // ------------------------------------------------------------
    // rising edge: sequencing and read fetch
    // ------------------------------------------------------------
    // [RULE5] command, latency, data
    always_ff @(posedge link.ck or posedge txnClear) begin
        if (txnClear) begin
            state    <= DEV_CMD;
            cmdCnt   <= 2'h0;
            cmdHi    <= 8'h00;
            isRead   <= 1'b0;
            isLinear <= 1'b0;
            extraLat <= 1'b0;
            latCnt   <= 8'h00;
            addr     <= 21'h000000;
            curAddr  <= 21'h000000;
            prefRow  <= 18'h00000;
            rdHi     <= 8'h00;
            rdLoNext <= 8'h00;
            wrHi     <= 8'h00;
            wrHiMask <= 1'b1;
            dataLive <= 1'b0;
        end else begin
            case (state)
                DEV_CMD: begin
                    // [RULE4] capture rising byte
                    cmdHi  <= link.dq;
                    cmdCnt <= cmdCnt + 2'h1;
                    // [RULE20] three words taken
                    if (cmdCnt == 2'(CMD_CYCLES)) begin
                        state    <= DEV_LAT;
                        isRead   <= cmdBits[CMD_RW_BIT];
                        isLinear <= cmdBits[CMD_LIN_BIT];
                        extraLat <= refreshDue;
                        latCnt   <= latLoad;
                        addr     <= cmdAddr;
                        prefRow  <= cmdRow + 18'h00001;
                    end
                end
                DEV_LAT: begin
                    if (latCnt == 8'h00) begin
                        state <= DEV_DATA;
                    end else begin
                        latCnt <= latCnt - 8'h01;
                    end
                end
                DEV_DATA: begin
                    // [RULE10] one word per cycle
                    curAddr  <= addr;
                    dataLive <= 1'b1;
                    addr     <= nextAddr;
                    // [RULE16] row prefetch ahead
                    if (isLinear && rowEnd) begin
                        prefRow <= prefRow + 18'h00001;
                    end
                    // [RULE3] word split into bytes
                    rdHi     <= memHi[addr];
                    rdLoNext <= memLo[addr];
                    wrHi     <= link.dq;
                    wrHiMask <= link.strobe;
                end
                default: begin
                    state <= DEV_CMD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // falling edge: command assembly and byte writes
    // ------------------------------------------------------------
    // only the lanes, strobe and select are read here; all other control comes
    // from the rising-edge process, so the two edges never fight
    always_ff @(negedge link.ck) begin
        if (state == DEV_CMD) begin
            // [RULE18] first byte lands in top bits
            cmdBits <= {cmdBits[CMD_W-2*DQ_W-1:0], cmdHi, link.dq};
        end
        rdLo <= rdLoNext;
        // the falling edge before the first data edge has no current
        // word yet; writing then would hit a stale address
        if (state == DEV_DATA && dataLive && !isRead && !link.csN) begin
            // [RULE8] masked bytes untouched
            if (!wrHiMask) begin
                memHi[curAddr] <= wrHi;
            end
            // [RULE14] byte placement by mask
            if (!link.strobe) begin
                memLo[curAddr] <= link.dq;
            end
        end
    end

    // ------------------------------------------------------------
    // hidden refresh
    // ------------------------------------------------------------
    // the array is only refreshed during the extra latency, so a
    // host that never deselects would starve it
    // [RULE1] refresh outside transfers
    always_ff @(posedge link.ck or posedge devReset) begin
        if (devReset) begin
            refreshDue <= 1'b0;
            burstCnt   <= 8'h00;
        end else begin
            if (state == DEV_LAT && extraLat && latCnt == 8'h00) begin
                refreshDue <= 1'b0;
                burstCnt   <= 8'h00;
            end else begin
                if (state == DEV_DATA && burstCnt != 8'hff) begin
                    burstCnt <= burstCnt + 8'h01;
                end
                if (burstCnt >= REFRESH_BUDGET) begin
                    refreshDue <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // lane drivers
    // ------------------------------------------------------------
    wire readData = (state == DEV_DATA) && isRead;
    // [RULE7] strobe follows clock, bytes edge aligned
    assign link.devDq   = link.ck ? rdHi : rdLo;
    assign link.devDqOe = readData && !txnClear;
    // [RULE6] latency request in command phase
    assign link.devStrobe = readData ? link.ck
                          : ((state == DEV_CMD) ? refreshDue : 1'b0);
    // [RULE21] released while deselected
    assign link.devStrobeOe = !txnClear
                            && ((state == DEV_CMD) || isRead);

endmodule : psr_device

// ### psr_host.sv
// host end of the link: clock divider, command issue, burst transfer
`timescale 1ns/10ps
module psr_host (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  reqValid,
    input  wire logic                  reqWrite,
    input  wire logic                  reqLinear,
    input  wire logic [psr_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic [7:0]            reqLen,
    output logic                       reqReady,
    input  wire logic [psr_pkg::WORD_W-1:0] wrData,
    input  wire logic [1:0]            wrMask,
    output logic                       wrTake,
    output logic [psr_pkg::WORD_W-1:0] rdData,
    output logic                       rdValid,
    output logic                       refreshSeen,
    psr_link_if.host                   link
);
    import psr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    psr_host_state_t   state;
    logic [1:0]        phase;
    logic [7:0]        cyc;
    logic [CMD_W-1:0]  cmdReg;
    logic              isWrite;
    logic [7:0]        len;
    logic              extra;
    logic [7:0]        rdCount;
    logic [DQ_W-1:0]   rdHiReg;
    logic              gotHi;
    logic              s1, s2, s3;
    logic [DQ_W-1:0]   d1, d2;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // [RULE2] bounded burst length
    wire [7:0] lenClamp = (reqLen == 8'h00) ? 8'h01
                        : ((reqLen > MAX_BURST) ? MAX_BURST : reqLen);
    // [RULE2] accept added latency
    wire [7:0] tot = extra ? 8'(REFRESH_LAT_CYCLES)
                           : 8'(INIT_LAT_CYCLES);
    wire [7:0] dStart = 8'(CMD_CYCLES + 1) + tot;
    wire [7:0] dLast  = dStart + len - 8'h01;
    wire [7:0] nCyc   = cyc + 8'h01;
    wire cmdNext = nCyc <= 8'(CMD_CYCLES);
    wire cmdNow  = cyc <= 8'(CMD_CYCLES);
    wire wrNext  = isWrite && nCyc >= dStart && nCyc <= dLast;
    wire wrNow   = isWrite && cyc >= dStart && cyc <= dLast;
    wire done    = isWrite ? (cyc == dLast)
                           : (cyc >= dStart && rdCount == len);
    wire sRise   = s2 && !s3 && cyc >= dStart;
    wire sFall   = !s2 && s3 && gotHi;
    wire [CMD_W-1:0] cmdNew = {!reqWrite, 1'b0, reqLinear, 11'h000,
                               reqAddr[ADDR_W-1:COL_W], 13'h0000,
                               reqAddr[COL_W-1:0]};

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        s1 <= link.strobe;
        s2 <= s1;
        s3 <= s2;
        d1 <= link.dq;
        d2 <= d1;
    end

    // ------------------------------------------------------------
    // sequencer; link clock is clk divided by four, lanes change
    // midway between its edges
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= HOST_IDLE;
            phase <= 2'h0;
            cyc <= 8'h00;
            cmdReg <= 48'h000000000000;
            isWrite <= 1'b0;
            len <= 8'h01;
            extra <= 1'b0;
            rdCount <= 8'h00;
            rdHiReg <= 8'h00;
            gotHi <= 1'b0;
            reqReady <= 1'b0;
            wrTake <= 1'b0;
            rdData <= 16'h0000;
            rdValid <= 1'b0;
            refreshSeen <= 1'b0;
            link.csN <= 1'b1;
            link.ck <= 1'b0;
            link.resetN <= 1'b0;
            link.hostDq <= 8'h00;
            link.hostDqOe <= 1'b0;
            link.hostStrobe <= 1'b0;
            link.hostStrobeOe <= 1'b0;
        end else begin
            link.resetN <= 1'b1;
            wrTake <= 1'b0;
            rdValid <= 1'b0;
            case (state)
                HOST_IDLE: begin
                    reqReady <= 1'b1;
                    if (reqValid && reqReady) begin
                        // [RULE17] select falls with clock low
                        link.csN <= 1'b0;
                        reqReady <= 1'b0;
                        cmdReg <= cmdNew;
                        isWrite <= reqWrite;
                        len <= lenClamp;
                        extra <= 1'b0;
                        rdCount <= 8'h00;
                        gotHi <= 1'b0;
                        phase <= 2'h3;
                        cyc <= 8'h00;
                        state <= HOST_RUN;
                    end
                end
                HOST_RUN: begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) begin
                        link.ck <= 1'b1;
                    end
                    if (phase == 2'h2) begin
                        link.ck <= 1'b0;
                    end
                    if (phase == 2'h2 && cyc == 8'h02) begin
                        // [RULE6] sample latency request
                        extra <= s2;
                        refreshSeen <= s2;
                    end
                    if (phase == 2'h3) begin
                        cyc <= nCyc;
                        link.hostDqOe <= cmdNext || wrNext;
                        link.hostStrobeOe <= wrNext;
                        // [RULE18] top byte first on the lanes
                        if (cmdNext) begin
                            link.hostDq <= cmdReg[CMD_W-1 -: DQ_W];
                            cmdReg <= cmdReg << DQ_W;
                        end else begin
                            // [RULE9] write byte centred
                            link.hostDq <= wrData[WORD_W-1 -: DQ_W];
                            link.hostStrobe <= wrMask[1];
                        end
                        // [RULE5] deselect ends transfer
                        if (done && cyc != 8'h00) begin
                            link.csN <= 1'b1;
                            link.hostDqOe <= 1'b0;
                            link.hostStrobeOe <= 1'b0;
                            state <= HOST_STOP;
                        end
                    end
                    if (phase == 2'h1) begin
                        if (cmdNow) begin
                            link.hostDq <= cmdReg[CMD_W-1 -: DQ_W];
                            cmdReg <= cmdReg << DQ_W;
                        end else if (wrNow) begin
                            // [RULE8] low byte with its mask
                            link.hostDq <= wrData[DQ_W-1:0];
                            link.hostStrobe <= wrMask[0];
                            wrTake <= 1'b1;
                        end
                    end
                    // [RULE7] bytes taken on strobe edges
                    if (sRise) begin
                        rdHiReg <= d2;
                        gotHi <= 1'b1;
                    end
                    if (sFall) begin
                        gotHi <= 1'b0;
                        if (rdCount != len) begin
                            rdData <= {rdHiReg, d2};
                            rdValid <= 1'b1;
                            rdCount <= rdCount + 8'h01;
                        end
                    end
                end
                HOST_STOP: begin
                    state <= HOST_IDLE;
                end
                default: begin
                    state <= HOST_IDLE;
                end
            endcase
        end
    end

endmodule : psr_host

// ### psr_link_checker.sv
// concurrent checks on the link between host and memory ends
`timescale 1ns/10ps
module psr_link_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic csN,
    input wire logic ck,
    input wire logic resetN,
    input wire logic hostDqOe,
    input wire logic hostStrobeOe,
    input wire logic [7:0] hostDq,
    input wire logic devDqOe,
    input wire logic devStrobeOe,
    input wire logic devStrobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_deselRelease; csN |-> !devDqOe && !devStrobeOe; endproperty
    property p_resetRelease; !resetN |-> !devDqOe && !devStrobeOe; endproperty
    property p_selIdleCk; $fell(csN) |-> !ck; endproperty
    property p_ckStill; csN && $past(csN) |-> !ck; endproperty
    property p_cmdStrobeOut; $fell(csN) |-> ##[0:1] devStrobeOe; endproperty
    property p_cmdHostDrives; $fell(csN) |=> hostDqOe && !devDqOe; endproperty
    // host lanes never move on the edge that moves the link clock
    property p_wrCentred;
        hostDqOe && $changed(ck) |-> $stable(hostDq);
    endproperty
    property p_frameEnd; $rose(csN) |-> !hostDqOe && !hostStrobeOe; endproperty
    property p_readStrobe; devDqOe |-> devStrobeOe && devStrobe == ck; endproperty
    property p_laneOwner; !(devDqOe && hostDqOe); endproperty
    property p_strobeOwner; !(devStrobeOe && hostStrobeOe); endproperty

    a_deselRelease: assert property (p_deselRelease)
        else $error("memory drives lanes while deselected");
    a_resetRelease: assert property (p_resetRelease)
        else $error("memory drives lanes in reset");
    a_selIdleCk: assert property (p_selIdleCk)
        else $error("select fell with link clock high");
    a_ckStill: assert property (p_ckStill)
        else $error("link clock moves between frames");
    a_cmdStrobeOut: assert property (p_cmdStrobeOut)
        else $error("strobe not driven in command phase");
    a_cmdHostDrives: assert property (p_cmdHostDrives)
        else $error("command bytes not driven by host");
    a_wrCentred: assert property (p_wrCentred)
        else $error("host lanes changed with the link clock");
    a_frameEnd: assert property (p_frameEnd)
        else $error("host still drives after deselect");
    a_readStrobe: assert property (p_readStrobe)
        else $error("read strobe not aligned to data");
    a_laneOwner: assert property (p_laneOwner)
        else $error("both ends drive the lanes");
    a_strobeOwner: assert property (p_strobeOwner)
        else $error("both ends drive the strobe");

    c_read: cover property (devDqOe);
    c_refresh: cover property (devStrobeOe && devStrobe && !devDqOe);
    c_mask: cover property (hostStrobeOe);
endmodule : psr_link_checker

// ### psr_link_if.sv
// eight-lane ddr link between host and pseudo-static memory
`timescale 1ns/10ps
interface psr_link_if;
    import psr_pkg::*;

    logic              csN;
    logic              ck;
    logic              resetN;
    logic [DQ_W-1:0]   hostDq;
    logic              hostDqOe;
    logic              hostStrobe;
    logic              hostStrobeOe;
    logic [DQ_W-1:0]   devDq;
    logic              devDqOe;
    logic              devStrobe;
    logic              devStrobeOe;
    logic [DQ_W-1:0]   dq;
    logic              strobe;

    // wire level from the enables; an undriven line reads low
    assign dq     = devDqOe ? devDq : (hostDqOe ? hostDq : 8'h00);
    assign strobe = devStrobeOe ? devStrobe
                  : (hostStrobeOe ? hostStrobe : 1'b0);

    modport host (
        output csN, ck, resetN, hostDq, hostDqOe, hostStrobe, hostStrobeOe,
        input  dq, strobe
    );

    modport device (
        input  csN, ck, resetN, dq, strobe,
        output devDq, devDqOe, devStrobe, devStrobeOe
    );

endinterface : psr_link_if

// ### psr_pkg.sv
// shared constants and types for the pseudo-static memory link
package psr_pkg;

    // ------------------------------------------------------------
    // link widths
    // ------------------------------------------------------------
    localparam int DQ_W      = 8;
    localparam int WORD_W    = 16;
    localparam int CMD_W     = 48;
    localparam int ADDR_W    = 21;
    localparam int COL_W     = 3;
    localparam int ROW_W     = ADDR_W - COL_W;
    localparam int MEM_WORDS = 1 << ADDR_W;

    // ------------------------------------------------------------
    // command/address field positions
    // ------------------------------------------------------------
    localparam int CMD_RW_BIT  = 47;
    localparam int CMD_LIN_BIT = 45;
    localparam int CMD_ROW_LSB = 16;
    localparam int CMD_COL_LSB = 0;

    // wrapped burst group of eight words
    localparam logic [ADDR_W-1:0] WRAP_MASK = 21'h000007;

    // ------------------------------------------------------------
    // timing counts, in link clock cycles
    // ------------------------------------------------------------
    localparam int CMD_CYCLES          = 3;
    localparam int INIT_LAT_CYCLES     = 6;
    localparam int REFRESH_LAT_CYCLES  = 2 * INIT_LAT_CYCLES;
    localparam logic [7:0] REFRESH_BUDGET = 8'h40;
    localparam logic [7:0] MAX_BURST      = 8'h20;

    // host system clocks per link clock period
    localparam int HOST_PHASES = 4;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEV_CMD  = 2'b00,
        DEV_LAT  = 2'b01,
        DEV_DATA = 2'b11
    } psr_dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_RUN  = 2'b01,
        HOST_STOP = 2'b11
    } psr_host_state_t;

endpackage : psr_pkg
